// *** logic/def_pkg.sv ***
// Constants, register map and carrier types for the decoder event interrupt flag block.
// Assumes one 250 MHz clock, synchronous active-high reset, Avalon-MM register access.
//
// What this block does
// - Interrupt pin is open-drain, asserted by pulling low.
// - Each flag has its own mask enable.
// - All masks disabled after reset.
// - Status reads return live state, not snapshots.
// - Flags live in four 8-bit status registers.
// - Only reading its status register clears flag.
// - Set wins over clear in same cycle.
// - Power-fail flag on supply failure during operation.
// - Flag on interlaced or non-interlaced detection.
// - Flag on horizontal PLL lock change.
// - Flag on vertical lock change.
// - Flag on field rate 50/60 Hz toggle.
// - Flag on capture-ready change.
// - Two-bit flag on colour standard change/loss.
// - Three flags on copy-protection level changes.
// - Flag on VPS identification found or lost.
// - Flag on wide-screen identification found or lost.
// - Flag on closed caption identification found/lost.
// - Flag on scaler output formatting error.
package def_pkg;

  // ****************************************************************
  // Register map, word addresses on a 32-bit Avalon-MM slave.
  // ****************************************************************
  localparam logic [3:0] ADDR_STAT0 = 4'h0; // Power and sync events.
  localparam logic [3:0] ADDR_STAT1 = 4'h1; // Standard and copy protection.
  localparam logic [3:0] ADDR_STAT2 = 4'h2; // Data slicer events.
  localparam logic [3:0] ADDR_STAT3 = 4'h3; // Scaler events.
  localparam logic [3:0] ADDR_MASK0 = 4'h4; // Mask for status 0.
  localparam logic [3:0] ADDR_MASK1 = 4'h5;
  localparam logic [3:0] ADDR_MASK2 = 4'h6;
  localparam logic [3:0] ADDR_MASK3 = 4'h7;
  localparam logic [3:0] ADDR_PEND = 4'h8; // Masked pending summary, read only.
  localparam int NUM_REGS = 4; // Number of status registers.
  localparam int REG_W = 8; // Status register width.
  localparam logic [7:0] MASK_RST = 8'h00; // Masks come up disabled.
  localparam logic [31:0] UNMAPPED_DATA = 32'h00000000; // Read value of holes.

  // ****************************************************************
  // Bit positions of events inside the status registers.
  // ****************************************************************
  localparam int S0_POWER_FAIL = 0;
  localparam int S0_INTERLACE = 1;
  localparam int S0_HPLL_LOCK = 2;
  localparam int S0_VLOCK = 3;
  localparam int S0_FIELD_RATE = 4;
  localparam int S0_CAPT_READY = 5;
  localparam int S1_COLOR_STD_LO = 0; // Two bits, 1:0.
  localparam int S1_COPY_A = 2;
  localparam int S1_COPY_B = 3;
  localparam int S1_COPY_C = 4;
  localparam int S2_VPS = 0;
  localparam int S2_WIDESCREEN = 1;
  localparam int S2_CAPTION = 2;
  localparam int S3_SCALER_ERR = 0;

  // Live status levels from the decoder sections; edges raise events.
  typedef struct packed {
    logic interlaced;
    logic hpll_locked;
    logic vlocked;
    logic field_60hz;
    logic capture_ready;
    logic [1:0] color_std;
    logic copy_a;
    logic copy_b;
    logic copy_c;
    logic vps_found;
    logic widescreen_found;
    logic caption_found;
  } def_live_t;

  // One-cycle event strobes that need no edge detection.
  typedef struct packed {
    logic power_fail;
    logic color_lost;
    logic scaler_format_error;
  } def_strobe_t;

  // Avalon-MM slave request.
  typedef struct packed {
    logic [3:0] address;
    logic read;
    logic write;
    logic [31:0] writedata;
  } def_av_req_t;

  // Whole module state.
  typedef struct packed {
    logic [NUM_REGS-1:0][REG_W-1:0] flags_r;
    logic [NUM_REGS-1:0][REG_W-1:0] mask_r;
    def_live_t live_r;
    logic live_valid_r;
    logic [31:0] readdata_r;
    logic waitreq_r;
    logic irq_oe_r;
  } def_state_t;

endpackage

// *** logic/def_flags.sv ***
// Event flag collector with per-flag masks and an open-drain interrupt request.
// Assumes live status levels and strobes are synchronous to CLK.
`timescale 1ns/1ps
module def_flags (
  // Clock and reset.
  input wire logic CLK,
  input wire logic RESET,
  // Decoder section status.
  input wire def_pkg::def_live_t LIVE,
  input wire def_pkg::def_strobe_t STROBE,
  // Avalon-MM slave.
  input wire def_pkg::def_av_req_t AV_REQ,
  output logic [31:0] AV_READDATA,
  output logic AV_WAITREQUEST,
  // Open-drain interrupt pin: drive value and enable.
  output logic INT_N_O,
  output logic INT_N_OE
);

  // ****************************************************************
  // State and next state.
  // ****************************************************************
  def_pkg::def_state_t st_r; // Registered state.
  def_pkg::def_state_t st_nxt; // Next state.
  logic [def_pkg::NUM_REGS-1:0][def_pkg::REG_W-1:0] ev; // Events this cycle.
  logic [def_pkg::NUM_REGS-1:0][def_pkg::REG_W-1:0] rd_clr; // Read clears.
  logic [def_pkg::NUM_REGS-1:0] pend; // Per-register masked pending.
  logic accept; // Access completes this edge.

  // Events are edges of the live levels plus direct strobes.
  always_comb
  begin
    ev = '0;
    // No edges before the first sample, so reset values fake no change.
    if (st_r.live_valid_r)
    begin
      ev[0][def_pkg::S0_INTERLACE] = LIVE.interlaced != st_r.live_r.interlaced;
      ev[0][def_pkg::S0_HPLL_LOCK] = LIVE.hpll_locked != st_r.live_r.hpll_locked;
      ev[0][def_pkg::S0_VLOCK] = LIVE.vlocked != st_r.live_r.vlocked;
      ev[0][def_pkg::S0_FIELD_RATE] = LIVE.field_60hz != st_r.live_r.field_60hz;
      ev[0][def_pkg::S0_CAPT_READY] = LIVE.capture_ready != st_r.live_r.capture_ready;
      ev[1][def_pkg::S1_COLOR_STD_LO +: 2] = LIVE.color_std ^ st_r.live_r.color_std;
      ev[1][def_pkg::S1_COPY_A] = LIVE.copy_a != st_r.live_r.copy_a;
      ev[1][def_pkg::S1_COPY_B] = LIVE.copy_b != st_r.live_r.copy_b;
      ev[1][def_pkg::S1_COPY_C] = LIVE.copy_c != st_r.live_r.copy_c;
      ev[2][def_pkg::S2_VPS] = LIVE.vps_found != st_r.live_r.vps_found;
      ev[2][def_pkg::S2_WIDESCREEN] =
        LIVE.widescreen_found != st_r.live_r.widescreen_found;
      ev[2][def_pkg::S2_CAPTION] = LIVE.caption_found != st_r.live_r.caption_found;
    end
    ev[0][def_pkg::S0_POWER_FAIL] = STROBE.power_fail;
    // Colour loss marks both standard bits, as the standard is then unknown.
    if (STROBE.color_lost)
    begin
      ev[1][def_pkg::S1_COLOR_STD_LO +: 2] = 2'h3;
    end
    ev[3][def_pkg::S3_SCALER_ERR] = STROBE.scaler_format_error;
  end

  // Each read of a status register clears only that register.
  assign accept = (AV_REQ.read | AV_REQ.write) & ~st_r.waitreq_r;

  generate
    for (genvar g = 0; g < def_pkg::NUM_REGS; g++)
    begin : g_reg
      // Clear only on a completed read of this exact address.
      assign rd_clr[g] = {def_pkg::REG_W{accept & AV_REQ.read &
        (AV_REQ.address == 4'(g))}};
      // Every flag ANDed with its own mask bit.
      assign pend[g] = |(st_r.flags_r[g] & st_r.mask_r[g]);
    end
  endgenerate

  // ****************************************************************
  // Next-state logic.
  // ****************************************************************
  always_comb
  begin
    st_nxt = st_r;
    st_nxt.live_r = LIVE;
    st_nxt.live_valid_r = 1'b1;
    for (int i = 0; i < def_pkg::NUM_REGS; i++)
    begin
      // Set has priority over a clear in the same cycle.
      st_nxt.flags_r[i] = (st_r.flags_r[i] & ~rd_clr[i]) | ev[i];
    end
    // One wait cycle per access keeps read data registered.
    st_nxt.waitreq_r = 1'b1;
    st_nxt.readdata_r = def_pkg::UNMAPPED_DATA;
    if ((AV_REQ.read | AV_REQ.write) & st_r.waitreq_r)
    begin
      st_nxt.waitreq_r = 1'b0;
      if (AV_REQ.read)
      begin
        unique case (AV_REQ.address)
          // Current flag contents, never a frozen copy.
          def_pkg::ADDR_STAT0: st_nxt.readdata_r = {24'h000000, st_r.flags_r[0]};
          def_pkg::ADDR_STAT1: st_nxt.readdata_r = {24'h000000, st_r.flags_r[1]};
          def_pkg::ADDR_STAT2: st_nxt.readdata_r = {24'h000000, st_r.flags_r[2]};
          def_pkg::ADDR_STAT3: st_nxt.readdata_r = {24'h000000, st_r.flags_r[3]};
          def_pkg::ADDR_MASK0: st_nxt.readdata_r = {24'h000000, st_r.mask_r[0]};
          def_pkg::ADDR_MASK1: st_nxt.readdata_r = {24'h000000, st_r.mask_r[1]};
          def_pkg::ADDR_MASK2: st_nxt.readdata_r = {24'h000000, st_r.mask_r[2]};
          def_pkg::ADDR_MASK3: st_nxt.readdata_r = {24'h000000, st_r.mask_r[3]};
          def_pkg::ADDR_PEND: st_nxt.readdata_r = {28'h0000000, pend};
          default: st_nxt.readdata_r = def_pkg::UNMAPPED_DATA;
        endcase
      end
    end
    // Mask writes take effect on the accepting edge; low byte lane only.
    if (accept & AV_REQ.write & (AV_REQ.address >= def_pkg::ADDR_MASK0) &
        (AV_REQ.address <= def_pkg::ADDR_MASK3))
    begin
      st_nxt.mask_r[AV_REQ.address[1:0]] = AV_REQ.writedata[7:0];
    end
    // Pull the pin low while any enabled flag is set, else release it.
    st_nxt.irq_oe_r = |pend;
  end

  // ****************************************************************
  // State register with synchronous reset.
  // ****************************************************************
  always_ff @(posedge CLK)
  begin
    if (RESET)
    begin
      st_r <= '0;
      st_r.mask_r <= {def_pkg::NUM_REGS{def_pkg::MASK_RST}};
      st_r.waitreq_r <= 1'b1;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  // Outputs come straight from flip-flops; the drive value is always low.
  assign AV_READDATA = st_r.readdata_r;
  assign AV_WAITREQUEST = st_r.waitreq_r;
  assign INT_N_O = 1'b0;
  assign INT_N_OE = st_r.irq_oe_r;

endmodule // def_flags

// *** sim/def_flags_chk.sv ***
// Port assertions for the event flag block.
// Assumes it is bound by name to every def_flags instance.
`timescale 1ns/1ps
module def_flags_chk (
  input wire logic CLK,
  input wire logic RESET,
  input wire def_pkg::def_live_t LIVE,
  input wire def_pkg::def_strobe_t STROBE,
  input wire def_pkg::def_av_req_t AV_REQ,
  input wire logic [31:0] AV_READDATA,
  input wire logic AV_WAITREQUEST,
  input wire logic INT_N_O,
  input wire logic INT_N_OE
);
  default clocking @(posedge CLK); endclocking
  default disable iff (RESET);
  logic [3:0][7:0] msk_r; // Shadow of accepted mask writes.
  logic [3:0] idle_r; // Cycles since the last accepted access, saturating.
  logic acc; // An access completes at this edge.
  assign acc = !AV_WAITREQUEST && (AV_REQ.read || AV_REQ.write);
  // The shadow lets the pin checks know which flags may raise the line.
  always_ff @(posedge CLK)
  begin
    msk_r <= RESET ? '0 : msk_r;
    idle_r <= RESET ? 4'hf : (acc ? 4'h0 : idle_r + {3'h0, idle_r != 4'hf});
    if (!RESET && acc && AV_REQ.write && AV_REQ.address[3:2] == 2'b01)
      msk_r[AV_REQ.address[1:0]] <= AV_REQ.writedata[7:0];
  end
  a_pin_drive: assert property (INT_N_O == 1'b0) else $error("pin drive not low");
  a_reset_quiet: assert property ($fell(RESET) |-> !INT_N_OE) else $error("irq after reset");
  a_one_wait: assert property ((AV_REQ.read || AV_REQ.write) && AV_WAITREQUEST
    |=> !AV_WAITREQUEST) else $error("access not answered");
  a_wait_pulse: assert property (!AV_WAITREQUEST |=> AV_WAITREQUEST) else $error("long answer");
  a_byte_wide: assert property (acc && AV_REQ.read |-> AV_READDATA[31:8] == 24'h0)
    else $error("upper read bits set");
  a_mask_back: assert property (acc && AV_REQ.read && AV_REQ.address[3:2] == 2'b01
    |-> AV_READDATA[7:0] == msk_r[AV_REQ.address[1:0]]) else $error("mask readback");
  a_clear_read: assert property ($fell(INT_N_OE) |-> idle_r <= 4'h3)
    else $error("irq fell without access");
  a_set_irq: assert property (STROBE.power_fail && msk_r[0][0] |-> ##[1:3] INT_N_OE)
    else $error("enabled event gave no irq");
  a_needs_mask: assert property (INT_N_OE |-> msk_r != '0 || $past(msk_r) != '0)
    else $error("irq with all masks off");
endmodule // def_flags_chk
bind def_flags def_flags_chk u_chk (.CLK(CLK), .RESET(RESET), .LIVE(LIVE), .STROBE(STROBE),
  .AV_REQ(AV_REQ), .AV_READDATA(AV_READDATA), .AV_WAITREQUEST(AV_WAITREQUEST),
  .INT_N_O(INT_N_O), .INT_N_OE(INT_N_OE));

// *** sim/def_host.sv ***
// Host side of the interrupt wire: a pull-up against an open-drain driver.
// Assumes the block drives INT_N_O only while INT_N_OE is high.
`timescale 1ns/1ps
module def_host (
  // Block drive.
  input wire logic INT_N_O,
  input wire logic INT_N_OE,
  // Resolved wire level.
  output logic INT_N
);
  // The pull-up returns the wire high whenever the block lets go.
  assign INT_N = INT_N_OE ? INT_N_O : 1'b1;
endmodule // def_host

// *** sim/testbench.sv ***
// Self-checking bench for the event flag block.
// Assumes one wait state per access, as the block answers.
`timescale 1ns/1ps
module testbench;
  logic CLK = 1'b0;
  logic RESET = 1'b1;
  def_pkg::def_live_t LIVE = '0;
  def_pkg::def_strobe_t STROBE = '0;
  def_pkg::def_av_req_t AV_REQ = '0;
  logic [31:0] AV_READDATA;
  logic AV_WAITREQUEST;
  logic INT_N_O;
  logic INT_N_OE;
  logic INT_N; // Resolved interrupt wire.
  logic [31:0] rd; // Data of the last read.
  logic [7:0] ev_exp [4] = '{8'h3e, 8'h1f, 8'h07, 8'h01}; // Every event once except power fail.
  int error_cnt = 0;
  int comparisons = 0;
  int cyc = 0;
  initial forever #2 CLK = ~CLK;
  def_flags u_dut (.CLK(CLK), .RESET(RESET), .LIVE(LIVE), .STROBE(STROBE), .AV_REQ(AV_REQ),
    .AV_READDATA(AV_READDATA), .AV_WAITREQUEST(AV_WAITREQUEST), .INT_N_O(INT_N_O),
    .INT_N_OE(INT_N_OE));
  def_host u_host (.INT_N_O(INT_N_O), .INT_N_OE(INT_N_OE), .INT_N(INT_N));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // One access; pf pulses power fail so that it lands on the accept edge.
  // The request holds until the rising edge that sees waitrequest low.
  task automatic bus(input logic [3:0] a, input logic w, input logic [31:0] d, input logic pf);
    @(posedge CLK);
    AV_REQ <= '{address: a, read: !w, write: w, writedata: d};
    do
    begin
      @(posedge CLK);
      STROBE.power_fail <= pf & AV_WAITREQUEST;
    end
    while (AV_WAITREQUEST !== 1'b0);
    rd = AV_READDATA;
    AV_REQ <= '0;
  endtask
  task automatic t_reset;
    for (int i = 4; i < 10; i++)
    begin
      bus(i[3:0], 1'b0, 32'h0, 1'b0);
      chk(rd, 32'h0);
    end
    chk({31'h0, INT_N}, 32'h1);
  endtask
  // All events but power fail at once, masks off; a write and other reads must not clear.
  task automatic t_events;
    @(posedge CLK);
    LIVE <= ~LIVE;
    STROBE <= '{power_fail: 1'b0, color_lost: 1'b1, scaler_format_error: 1'b1};
    @(posedge CLK);
    STROBE <= '0;
    bus(4'h0, 1'b1, 32'hff, 1'b0);
    for (int i = 0; i < 4; i++)
    begin
      bus(i[3:0], 1'b0, 32'h0, 1'b0);
      chk(rd, {24'h0, ev_exp[i]});
      bus(i[3:0], 1'b0, 32'h0, 1'b0);
      chk(rd, 32'h0);
    end
    chk({31'h0, INT_N}, 32'h1);
  endtask
  // Only power fail enabled; it arrives on the very edge that clears.
  task automatic t_irq;
    bus(4'h4, 1'b1, 32'h101, 1'b0);
    bus(4'h4, 1'b0, 32'h0, 1'b0);
    chk(rd, 32'h1);
    LIVE.hpll_locked <= ~LIVE.hpll_locked;
    repeat (4) @(posedge CLK);
    chk({31'h0, INT_N}, 32'h1);
    bus(4'h0, 1'b0, 32'h0, 1'b1);
    chk(rd, 32'h4);
    repeat (3) @(posedge CLK);
    chk({31'h0, INT_N}, 32'h0);
    bus(4'h8, 1'b0, 32'h0, 1'b0);
    chk(rd, 32'h1);
    bus(4'h0, 1'b0, 32'h0, 1'b0);
    chk(rd, 32'h1);
    repeat (3) @(posedge CLK);
    chk({31'h0, INT_N}, 32'h1);
  endtask
  task automatic give_verdict;
    $display("errors %0d comparisons %0d", error_cnt, comparisons);
    if (error_cnt == 0 && comparisons > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  // The whole run needs under a hundred cycles; this ceiling stops a hang.
  always @(posedge CLK)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      error_cnt++;
      give_verdict();
    end
  end
  initial
  begin
    repeat (2) @(posedge CLK);
    RESET <= 1'b0;
    t_reset();
    t_events();
    t_irq();
    give_verdict();
  end
endmodule // testbench
